// >>> rtl/mmd_memory_map.sv
`timescale 1ns/1ps
// How it works
// - Code storage returns one byte every clock, registered.
// - Program addresses are 16 bits; only on-chip storage answers.
// - On-chip code occupies 0000h to 07FFh.
// - No external bus exists; out-of-range addresses never leave the block.
// - Vectors sit in the lowest 59 code bytes, inside on-chip storage.
// - Table reads reach every byte of the 2K code space.
// - With signature select set, table reads go to signature arrays.
// - User signature answers table reads at 0040h to 007Fh.
// - Factory signature answers table reads at 0000h to 001Fh.
// - No CPU path writes the signature arrays.
// - Factory array holds the device ID, read via table reads.
// - Security lock blocks signature writes, reads always allowed.
// - Auxiliary control at A2h, select bit 3 resets to 0.
// - Lower 128 data bytes are RAM, direct and indirect.
// - Upper 128 data addresses reach SFRs by direct addressing only.
// - Indirect upper-half accesses return invalid data, reach no SFR.
// - Lowest 32 RAM bytes are four banks of eight registers.
// - Status word bits 3 and 4 pick the bank for register operands.
module mmd_memory_map
  import mmd_pkg::*;
#(
  parameter int RAM_BYTES = MMD_RAM_BYTES
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire mmd_code_req_t code_req,
  output logic      [7:0]    code_data,
  output logic               code_valid,
  output logic               code_range_err,
  input  wire mmd_data_req_t data_req,
  output logic      [7:0]    data_rdata,
  output logic               data_rvalid,
  output logic               sfr_ext_sel,
  output logic      [7:0]    sfr_ext_addr,
  output logic      [7:0]    sfr_ext_wdata,
  output logic               sfr_ext_write,
  input  wire logic [7:0]    sfr_ext_rdata,
  output logic      [7:0]    program_status_word,
  output logic      [1:0]    active_bank,
  output logic               signature_read_select,
  input  wire logic          prog_code_wr,
  input  wire logic [10:0]   prog_code_addr,
  input  wire logic [7:0]    prog_code_data,
  input  wire logic          prog_sig_wr,
  input  wire logic [5:0]    prog_sig_addr,
  input  wire logic [7:0]    prog_sig_data,
  input  wire logic          security_lock
);

  logic [7:0]  ram [RAM_BYTES];
  logic [7:0]  auxiliary_control;
  logic [7:0]  eff_addr;
  logic        is_upper;
  logic        sfr_direct;
  logic        ram_hit;
  logic        use_sig;
  logic        code_hit;
  logic [7:0]  code_byte;
  logic [7:0]  sig_byte;
  logic        use_sig_q;
  logic        code_hit_q;
  logic        sig_hit;
  logic        sig_hit_q;
  logic [1:0]  rsrc_q;
  logic [7:0]  ram_q;
  logic [7:0]  sfr_local_q;
  logic        lock_q1;
  logic        lock_q2;

  localparam logic [1:0] SRC_RAM     = 2'h0;
  localparam logic [1:0] SRC_SFR_LOC = 2'h1;
  localparam logic [1:0] SRC_SFR_EXT = 2'h2;
  localparam logic [1:0] SRC_INVALID = 2'h3;

  // Bank bits come straight from the status word
  assign active_bank           = {program_status_word[MMD_BANK_HI_BIT],
                                  program_status_word[MMD_BANK_LO_BIT]};
  assign signature_read_select = auxiliary_control[MMD_SIG_SEL_BIT];

  // Program-space decode; table reads with select set go to signatures
  assign use_sig  = (code_req.kind == MMD_TABLE) && signature_read_select;
  assign code_hit = mmd_in_code(code_req.addr);
  assign sig_hit  = (code_req.addr >= MMD_USIG_FIRST && code_req.addr <= MMD_USIG_LAST)
                 || (code_req.addr <= MMD_FSIG_LAST);

  // Low 11 bits index code storage; vectors lie in the first 59 bytes
  mmd_code_store #(
    .DEPTH (MMD_CODE_BYTES),
    .IW    (MMD_CODE_IW)
  ) u_code (
    .clk_sys   (clk_sys),
    .load_en   (prog_code_wr),
    .load_addr (prog_code_addr),
    .load_data (prog_code_data),
    .rd_addr   (code_req.addr[MMD_CODE_IW-1:0]),
    .rd_data   (code_byte)
  );

  // Lock is a static strap from outside, synchronised before use
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lock_q1 <= 1'b0;
      lock_q2 <= 1'b0;
    end else begin
      lock_q1 <= security_lock;
      lock_q2 <= lock_q1;
    end
  end

  // Only the programming port writes signatures; no CPU write path
  mmd_sig_store u_sig (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .prog_wr_en   (prog_sig_wr),
    .prog_wr_addr (prog_sig_addr),
    .prog_wr_data (prog_sig_data),
    .lock_active  (lock_q2),
    .rd_addr      (code_req.addr[6:0]),
    .rd_data      (sig_byte)
  );

  // Remember source selection to match the registered read data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      use_sig_q  <= 1'b0;
      code_hit_q <= 1'b0;
      sig_hit_q  <= 1'b0;
      code_valid <= 1'b0;
    end else begin
      use_sig_q  <= use_sig;
      code_hit_q <= code_hit;
      sig_hit_q  <= sig_hit;
      code_valid <= code_req.valid;
    end
  end

  // Beyond 07FFh there is no memory and no external cycle; read back all ones
  always_comb begin
    if (use_sig_q) begin
      code_data = sig_hit_q ? sig_byte : MMD_INVALID_DATA;
    end else if (code_hit_q) begin
      code_data = code_byte;
    end else begin
      code_data = MMD_INVALID_DATA;
    end
  end
  assign code_range_err = code_valid && !use_sig_q && !code_hit_q;

  // Data-space decode; register operands map into the active bank
  assign eff_addr   = mmd_eff_addr(data_req, active_bank);
  assign is_upper   = eff_addr >= MMD_UPPER_BASE;
  assign ram_hit    = !is_upper;
  assign sfr_direct = is_upper && !data_req.indirect;

  // SFRs not kept here are passed to the owning peripheral
  assign sfr_ext_sel   = data_req.valid && sfr_direct
                      && eff_addr != MMD_AUX_CTRL_ADDR && eff_addr != MMD_STATUS_ADDR;
  assign sfr_ext_addr  = eff_addr;
  assign sfr_ext_wdata = data_req.wdata;
  assign sfr_ext_write = data_req.write;

  // Internal RAM, written on direct or indirect lower-half access
  always_ff @(posedge clk_sys) begin
    if (data_req.valid && data_req.write && ram_hit) begin
      ram[eff_addr[6:0]] <= data_req.wdata;
    end
    ram_q <= ram[eff_addr[6:0]];
  end

  // Auxiliary control: only the select bit is stored, the rest read zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      auxiliary_control <= 8'h00;
      auxiliary_control[MMD_SIG_SEL_BIT] <= MMD_SIG_SEL_RESET;
    end else if (data_req.valid && data_req.write && sfr_direct && eff_addr == MMD_AUX_CTRL_ADDR) begin
      auxiliary_control[MMD_SIG_SEL_BIT] <= data_req.wdata[MMD_SIG_SEL_BIT];
    end
  end

  // Status word kept here because it steers bank selection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      program_status_word <= MMD_STATUS_RESET;
    end else if (data_req.valid && data_req.write && sfr_direct && eff_addr == MMD_STATUS_ADDR) begin
      program_status_word <= data_req.wdata;
    end
  end

  // Read-source pipeline; indirect upper-half reads are flagged invalid
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsrc_q      <= SRC_RAM;
      sfr_local_q <= 8'h00;
      data_rvalid <= 1'b0;
    end else begin
      data_rvalid <= data_req.valid && !data_req.write;
      sfr_local_q <= (eff_addr == MMD_STATUS_ADDR) ? program_status_word : auxiliary_control;
      if (ram_hit) begin
        rsrc_q <= SRC_RAM;
      end else if (!sfr_direct) begin
        rsrc_q <= SRC_INVALID;
      end else if (eff_addr == MMD_AUX_CTRL_ADDR || eff_addr == MMD_STATUS_ADDR) begin
        rsrc_q <= SRC_SFR_LOC;
      end else begin
        rsrc_q <= SRC_SFR_EXT;
      end
    end
  end

  // External SFR data is expected one cycle after the select
  always_comb begin
    case (rsrc_q)
      SRC_RAM:     data_rdata = ram_q;
      SRC_SFR_LOC: data_rdata = sfr_local_q;
      SRC_SFR_EXT: data_rdata = sfr_ext_rdata;
      default:     data_rdata = MMD_INVALID_DATA;
    endcase
  end

endmodule // mmd_memory_map

// >>> rtl/mmd_pkg.sv
package mmd_pkg;

  // Program space
  localparam int          MMD_CODE_AW        = 16;         // Full linear program address width (64K)
  localparam int          MMD_CODE_BYTES     = 2048;       // Implemented on-chip code storage
  localparam int          MMD_CODE_IW        = 11;         // Index width of on-chip code storage
  localparam logic [15:0] MMD_CODE_LAST      = 16'h07FF;
  localparam logic [15:0] MMD_VECTOR_SPAN    = 16'h003B;   // 59 bytes of reset/interrupt vectors

  // Signature arrays
  localparam int          MMD_USIG_BYTES     = 64;
  localparam int          MMD_FSIG_BYTES     = 32;
  localparam logic [15:0] MMD_USIG_FIRST     = 16'h0040;
  localparam logic [15:0] MMD_USIG_LAST      = 16'h007F;
  localparam logic [15:0] MMD_FSIG_FIRST     = 16'h0000;
  localparam logic [15:0] MMD_FSIG_LAST      = 16'h001F;

  // Data space
  localparam int          MMD_RAM_BYTES      = 128;
  localparam logic [7:0]  MMD_UPPER_BASE     = 8'h80;
  localparam logic [7:0]  MMD_BANK_SPAN      = 8'h20;      // 4 banks of 8 registers
  localparam logic [7:0]  MMD_INVALID_DATA   = 8'hFF;      // Returned for indirect upper-half reads

  // Special-function registers handled here
  localparam logic [7:0]  MMD_AUX_CTRL_ADDR  = 8'hA2;
  localparam logic [7:0]  MMD_STATUS_ADDR    = 8'hD0;
  localparam int          MMD_SIG_SEL_BIT    = 3;
  localparam int          MMD_BANK_LO_BIT    = 3;
  localparam int          MMD_BANK_HI_BIT    = 4;
  localparam logic        MMD_SIG_SEL_RESET  = 1'b0;
  localparam logic [7:0]  MMD_STATUS_RESET   = 8'h00;

  // Factory signature content; arbitrary neutral value
  localparam logic [7:0]  MMD_DEVICE_ID_BYTE = 8'h5A;

  // Kinds of program-space read
  typedef enum logic [1:0] {
    MMD_FETCH = 2'h0,
    MMD_TABLE = 2'h1
  } mmd_code_kind_t;

  // Data-space access request
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       indirect;
    logic       reg_mode;    // Register-addressed operand, addr[2:0] is the register
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmd_data_req_t;

  // Program-space read request
  typedef struct packed {
    logic           valid;
    mmd_code_kind_t kind;
    logic [15:0]    addr;
  } mmd_code_req_t;

  // Effective data address from a request and the active bank
  function automatic logic [7:0] mmd_eff_addr(input mmd_data_req_t req, input logic [1:0] bank);
    logic [7:0] a;
    a = req.addr;
    if (req.reg_mode) begin
      a = {3'b000, bank, req.addr[2:0]};
    end
    return a;
  endfunction

  // True when a program address lands in implemented code storage
  function automatic logic mmd_in_code(input logic [15:0] addr);
    return addr <= MMD_CODE_LAST;
  endfunction

endpackage

// >>> rtl/mmd_code_store.sv
`timescale 1ns/1ps
// On-chip code storage with a load port; one byte per clock on the read side
module mmd_code_store
  import mmd_pkg::*;
#(
  parameter int DEPTH = MMD_CODE_BYTES,
  parameter int IW    = MMD_CODE_IW
) (
  input  wire logic          clk_sys,
  input  wire logic          load_en,
  input  wire logic [IW-1:0] load_addr,
  input  wire logic [7:0]    load_data,
  input  wire logic [IW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem [DEPTH];

  // Load path belongs to the programming side, not the CPU
  always_ff @(posedge clk_sys) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // Registered read; no reset so it maps onto block memory
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end

endmodule // mmd_code_store

// >>> rtl/mmd_sig_store.sv
`timescale 1ns/1ps
// Signature arrays: user array writable only by the programming side, factory array fixed
module mmd_sig_store
  import mmd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       prog_wr_en,
  input  wire logic [5:0] prog_wr_addr,
  input  wire logic [7:0] prog_wr_data,
  input  wire logic       lock_active,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] user_sig [MMD_USIG_BYTES];
  logic [7:0] next_rd_data;

  // Security lock blocks writes but never reads
  always_ff @(posedge clk_sys) begin
    if (prog_wr_en && !lock_active) begin
      user_sig[prog_wr_addr] <= prog_wr_data;
    end
  end

  // Factory array holds the device ID, repeated across its 32 bytes
  always_comb begin
    next_rd_data = 8'h00;
    if (16'(rd_addr) >= MMD_USIG_FIRST && 16'(rd_addr) <= MMD_USIG_LAST) begin
      next_rd_data = user_sig[rd_addr[5:0]];
    end else if (16'(rd_addr) <= MMD_FSIG_LAST) begin
      next_rd_data = MMD_DEVICE_ID_BYTE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule // mmd_sig_store

// >>> tb/mmd_memory_map_chk.sv
`timescale 1ns/1ps
// Port-level checks on the decoder, one clock domain
module mmd_memory_map_chk
  import mmd_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          nrst,
  input wire mmd_code_req_t code_req,
  input wire logic [7:0]    code_data,
  input wire logic          code_valid,
  input wire logic          code_range_err,
  input wire mmd_data_req_t data_req,
  input wire logic [7:0]    data_rdata,
  input wire logic          data_rvalid,
  input wire logic          sfr_ext_sel,
  input wire logic [7:0]    sfr_ext_addr,
  input wire logic [7:0]    program_status_word,
  input wire logic [1:0]    active_bank,
  input wire logic          signature_read_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Request shapes used by the two-step properties
  sequence s_fetch_high;
    code_req.valid && code_req.kind == MMD_FETCH && code_req.addr > MMD_CODE_LAST;
  endsequence
  sequence s_fsig_read;
    code_req.valid && code_req.kind == MMD_TABLE && signature_read_select && code_req.addr <= MMD_FSIG_LAST;
  endsequence
  sequence s_ind_upper_rd;
    data_req.valid && !data_req.write && data_req.indirect && !data_req.reg_mode && data_req.addr[7];
  endsequence
  a_code_every: assert property (code_req.valid |=> code_valid)
    else $error("code byte missing");
  a_code_idle: assert property (!code_req.valid |=> !code_valid)
    else $error("code byte without request");
  a_range_flag: assert property (s_fetch_high |=> code_range_err && code_data == MMD_INVALID_DATA)
    else $error("out of range fetch not flagged");
  a_fsig_id: assert property (s_fsig_read |=> code_data == MMD_DEVICE_ID_BYTE)
    else $error("factory signature byte wrong");
  a_data_answer: assert property (data_req.valid && !data_req.write |=> data_rvalid)
    else $error("data read not answered");
  a_indirect_ff: assert property (s_ind_upper_rd |=> data_rdata == MMD_INVALID_DATA)
    else $error("indirect upper read not invalid");
  a_no_ext_ind: assert property (data_req.valid && data_req.indirect |-> !sfr_ext_sel)
    else $error("indirect access reached sfr");
  a_ext_direct: assert property (data_req.valid && !data_req.indirect && !data_req.reg_mode && data_req.addr[7]
    && data_req.addr != MMD_AUX_CTRL_ADDR && data_req.addr != MMD_STATUS_ADDR
    |-> sfr_ext_sel && sfr_ext_addr == data_req.addr)
    else $error("direct upper access not routed");
  a_bank_pick: assert property (active_bank == program_status_word[4:3])
    else $error("bank not from status word");
  a_sel_write: assert property (data_req.valid && data_req.write && !data_req.indirect && !data_req.reg_mode
    && data_req.addr == MMD_AUX_CTRL_ADDR |=> signature_read_select == $past(data_req.wdata[3]))
    else $error("select bit not written");
endmodule // mmd_memory_map_chk

bind mmd_memory_map mmd_memory_map_chk i_chk (.clk_sys, .nrst, .code_req, .code_data, .code_valid,
  .code_range_err, .data_req, .data_rdata, .data_rvalid, .sfr_ext_sel, .sfr_ext_addr,
  .program_status_word, .active_bank, .signature_read_select);

// >>> tb/mmd_sfr_model.sv
`timescale 1ns/1ps
// Stand-in for the sfr block beyond the decoder; reads return addr xor A5
module mmd_sfr_model (
  input  wire logic       clk_sys,
  input  wire logic       sfr_ext_sel,
  input  wire logic       sfr_ext_write,
  input  wire logic [7:0] sfr_ext_addr,
  output logic      [7:0] sfr_ext_rdata
);
  logic [7:0] held = 8'h00;
  logic       held_ok = 1'b0;
  // Data holds through the two cycles after select, then toggles each cycle so later stale reads show
  always @(posedge clk_sys) begin
    held_ok <= sfr_ext_sel && !sfr_ext_write;
    held    <= sfr_ext_sel ? (sfr_ext_addr ^ 8'hA5) : ~held;
  end
  // A new select in the answer cycle must not disturb the answer of the previous one
  assign sfr_ext_rdata = held_ok ? held : ~held;
endmodule // mmd_sfr_model

// >>> tb/mmd_memory_map_tb_top.sv
`timescale 1ns/1ps
module mmd_memory_map_tb_top;
  import mmd_pkg::*;
  typedef struct packed {logic wr; logic ind; logic rm; logic [7:0] addr; logic [7:0] wd;} mmd_row_t;
  logic          clk_sys, nrst, code_valid, code_range_err, data_rvalid, sfr_ext_sel, sfr_ext_write;
  logic          signature_read_select, prog_code_wr, prog_sig_wr, security_lock;
  logic [7:0]    code_data, data_rdata, sfr_ext_addr, sfr_ext_rdata, program_status_word, sfr_ext_wdata;
  logic [7:0]    prog_code_data, prog_sig_data;
  logic [1:0]    active_bank;
  logic [10:0]   prog_code_addr;
  logic [5:0]    prog_sig_addr;
  mmd_code_req_t code_req;
  mmd_data_req_t data_req;
  int            errors, samples_checked, cycles;
  // Code bytes spread over the vectors, the table area and the top byte
  logic [10:0]   caddr [5] = '{11'h000, 11'h03A, 11'h040, 11'h041, 11'h7FF};
  logic [7:0]    cdat  [5] = '{8'hA1, 8'hB2, 8'hD4, 8'hE5, 8'hC3};
  // Data rows: for reads wd holds the expected byte
  mmd_row_t      rows [15] = '{
    '{1, 0, 0, 8'h05, 8'h11}, '{0, 1, 0, 8'h05, 8'h11}, '{1, 0, 0, 8'hD0, 8'h08},
    '{1, 0, 1, 8'h02, 8'h33}, '{0, 0, 0, 8'h0A, 8'h33}, '{1, 1, 0, 8'h90, 8'h44},
    '{0, 1, 0, 8'h90, 8'hFF}, '{0, 0, 0, 8'hD0, 8'h08}, '{1, 0, 0, 8'h1F, 8'h77},
    '{1, 0, 0, 8'hD0, 8'h18}, '{0, 0, 1, 8'h07, 8'h77}, '{0, 0, 0, 8'hA2, 8'h00},
    '{0, 0, 0, 8'h85, 8'h20}, '{1, 0, 0, 8'h7F, 8'h5C}, '{0, 1, 0, 8'h7F, 8'h5C}};

  mmd_memory_map i_dut (.clk_sys, .nrst, .code_req, .code_data, .code_valid, .code_range_err, .data_req,
    .data_rdata, .data_rvalid, .sfr_ext_sel, .sfr_ext_addr, .sfr_ext_wdata, .sfr_ext_write, .sfr_ext_rdata,
    .program_status_word, .active_bank, .signature_read_select, .prog_code_wr, .prog_code_addr,
    .prog_code_data, .prog_sig_wr, .prog_sig_addr, .prog_sig_data, .security_lock);
  mmd_sfr_model i_sfr (.clk_sys, .sfr_ext_sel, .sfr_ext_write, .sfr_ext_addr, .sfr_ext_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the roughly 60 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held from one falling edge to the next; valid stays up for back-to-back use
  task automatic code_rd(input mmd_code_kind_t k, input logic [15:0] a, input logic [7:0] exp);
    code_req = {1'b1, k, a};
    @(negedge clk_sys);
    chk({code_valid, code_data}, {1'b1, exp});
  endtask

  task automatic data_op(input mmd_row_t r);
    data_req = {1'b1, r.wr, r.ind, r.rm, r.addr, r.wd};
    @(negedge clk_sys);
    if (!r.wr) chk({data_rvalid, data_rdata}, {1'b1, r.wd});
  endtask

  initial begin
    {nrst, prog_code_wr, prog_sig_wr, security_lock} = '0;
    {code_req, data_req, prog_code_addr, prog_code_data, prog_sig_addr, prog_sig_data} = '0;
    repeat (8) @(negedge clk_sys);
    chk({code_valid, data_rvalid, signature_read_select, 6'h00}, 9'h000);
    chk({1'b0, program_status_word}, 9'h000);
    nrst = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      prog_code_wr = 1'b1;
      prog_code_addr = caddr[i];
      prog_code_data = cdat[i];
      @(negedge clk_sys);
    end
    prog_code_wr = 1'b0;
    // Back-to-back fetches, then table reads of the same bytes
    for (int i = 0; i < 5; i++) code_rd(MMD_FETCH, {5'h00, caddr[i]}, cdat[i]);
    for (int i = 0; i < 5; i++) code_rd(MMD_TABLE, {5'h00, caddr[i]}, cdat[i]);
    code_rd(MMD_FETCH, 16'h0800, 8'hFF);
    chk({1'b0, 7'h00, code_range_err}, 9'h001);
    code_rd(MMD_FETCH, 16'hFFFF, 8'hFF);
    code_req.valid = 1'b0;
    $display("test code space done");
    foreach (rows[i]) data_op(rows[i]);
    // Direct write to a peripheral register is passed straight through
    data_req = {1'b1, 1'b1, 2'b00, 8'h85, 8'h3C};
    #5;
    chk({sfr_ext_sel, sfr_ext_wdata}, {1'b1, 8'h3C});
    chk({sfr_ext_write, sfr_ext_addr}, {1'b1, 8'h85});
    @(negedge clk_sys);
    data_req.valid = 1'b0;
    $display("test data space done");
    // User bytes 0 and 1, then a locked attempt to overwrite byte 1
    for (int i = 0; i < 3; i++) begin
      // Lock must pass its synchroniser before the blocked write is tried
      if (i == 2) begin
        prog_sig_wr = 1'b0;
        security_lock = 1'b1;
        repeat (3) @(negedge clk_sys);
      end
      prog_sig_wr = 1'b1;
      prog_sig_addr = (i == 0) ? 6'h00 : 6'h01;
      prog_sig_data = (i == 0) ? 8'hC3 : (i == 1) ? 8'h66 : 8'h99;
      @(negedge clk_sys);
    end
    prog_sig_wr = 1'b0;
    data_op('{1, 0, 0, 8'hA2, 8'h08});
    data_req.valid = 1'b0;
    code_rd(MMD_TABLE, 16'h0000, MMD_DEVICE_ID_BYTE);
    code_rd(MMD_TABLE, 16'h001F, MMD_DEVICE_ID_BYTE);
    code_rd(MMD_TABLE, 16'h0040, 8'hC3);
    code_rd(MMD_TABLE, 16'h0041, 8'h66);
    code_rd(MMD_TABLE, 16'h0020, 8'hFF);
    code_rd(MMD_FETCH, 16'h0040, 8'hD4);
    code_req.valid = 1'b0;
    data_op('{0, 0, 0, 8'hA2, 8'h08});
    data_req.valid = 1'b0;
    $display("test signature done");
    // Reset in mid-run clears the select bit and the status word
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({code_valid, signature_read_select, program_status_word[6:0]}, 9'h000);
    nrst = 1'b1;
    code_rd(MMD_TABLE, 16'h0040, 8'hD4);
    code_req.valid = 1'b0;
    $display("test second reset done");
    @(negedge clk_sys);
    stop_test();
  end
endmodule // mmd_memory_map_tb_top
